// [shared/gwt_consts.svh]
// register map, field positions and reset values of the wake-up timer block
//------------------------------------------------------------
// Functional notes
// - capture armed only while bit 17 set
// - bits 16:12 pick event, source minus two
// - bits 11:9 pick core, crystal, gpio sources
// - bit 8 set counts up, default down
// - bit 7 enables counting, off at reset
// - bit 6 periodic when set, else free-running
// - bits 5:4 binary or hms, 23 or 255 hours
// - prescale codes divide by 1,16,256,32768
// - any write to clear location drops interrupt
// - selected event loads count into capture
// - wake-up counter has load and live count
// - bits 10:9 pick crystal, oscillator or core
// - wake-up runs while core clock stopped, except on core source
// - wake-up expiry triggers converter start
// - any write to wake-up clear drops interrupt
// - wake-up count is read-only, writes ignored
// - third timer runs oscillator divided 1,16,256
// - periodic runs load to terminal, then reloads
// - free-running wraps at zero or full scale
// - interrupt each time terminal count reached
//------------------------------------------------------------
`ifndef GWT_CONSTS_SVH
`define GWT_CONSTS_SVH

// byte addresses
`define GWT_GP_LOAD   32'hFFFF0320
`define GWT_GP_COUNT  32'hFFFF0324
`define GWT_GP_CTRL   32'hFFFF0328
`define GWT_GP_CLR    32'hFFFF032C
`define GWT_GP_CAP    32'hFFFF0330
`define GWT_WK_LOAD   32'hFFFF0340
`define GWT_WK_COUNT  32'hFFFF0344
`define GWT_WK_CTRL   32'hFFFF0348
`define GWT_WK_CLR    32'hFFFF034C
`define GWT_T3_LOAD   32'hFFFF0360
`define GWT_T3_COUNT  32'hFFFF0364
`define GWT_T3_CTRL   32'hFFFF0368
`define GWT_T3_CLR    32'hFFFF036C

// control fields
`define GWT_CAP_EN    17
`define GWT_EVT_HI    16
`define GWT_EVT_LO    12
`define GWT_CS_HI     11
`define GWT_CS_LO     9
`define GWT_WCS_HI    10
`define GWT_UP        8
`define GWT_EN        7
`define GWT_PER       6
`define GWT_FMT_HI    5
`define GWT_FMT_LO    4
`define GWT_PRE_HI    3
`define GWT_PRE_LO    0
`define GWT_T3P_LO    2

// writable bits of each control register
`define GWT_GP_MASK   32'h0003FFFF
`define GWT_WK_MASK   32'h000007FF
`define GWT_T3_MASK   32'h000001CC

// source, prescale and format codes
`define GWT_GCS_CORE  3'h0
`define GWT_GCS_XTAL  3'h1
`define GWT_GCS_GPIO1 3'h2
`define GWT_GCS_GPIO2 3'h3
`define GWT_WCS_OSC   2'h2
`define GWT_WCS_CORE  2'h3
`define GWT_PRE_16    4'h4
`define GWT_PRE_256   4'h8
`define GWT_PRE_32K   4'hF
`define GWT_LIM_16    15'h000F
`define GWT_LIM_256   15'h00FF
`define GWT_LIM_32K   15'h7FFF
`define GWT_HR23      8'h17
`define GWT_HR255     8'hFF
`define GWT_SEC_MAX   8'h3B
`define GWT_HUN_MAX   8'h63

// reset values
`define GWT_COUNT_RST 32'h0FFFFFFF

`endif

// [shared/gwt_pkg.sv]
// types shared by the wake-up timer block
package gwt_pkg;
  // bus handshake states
  typedef enum logic [1:0] {
    GWT_BUS_IDLE = 2'b01,
    GWT_BUS_ACK  = 2'b10
  } gwt_bus_t;

  // state of one counter channel
  typedef struct packed {
    logic [14:0] pre;
    logic [31:0] count;
    logic        irq;
    logic        expired;
  } gwt_cnt_t;

  // state of the top level
  typedef struct packed {
    gwt_bus_t    bus;
    logic        wreq;
    logic [31:0] rdata;
    logic [31:0] gp_ctrl;
    logic [31:0] gp_load;
    logic [31:0] gp_cap;
    logic [31:0] wk_ctrl;
    logic [31:0] wk_load;
    logic [31:0] t3_ctrl;
    logic [31:0] t3_load;
    logic [3:0]  sync1;
    logic [3:0]  sync2;
    logic [3:0]  prev;
    logic [31:0] evt_prev;
    logic        gp_trig;
    logic        wk_trig;
  } gwt_top_t;
endpackage

// [rtl/gwt_counter.sv]
// one prescaled up/down counter channel with load, wrap and interrupt
`timescale 1ns/100ps
`include "gwt_consts.svh"
module gwt_counter #(
  parameter int unsigned WIDTH   = 32,
  parameter bit          DIV_32K = 1'b1
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // source tick and control
  input  wire logic        tick,
  input  wire logic        enable,
  input  wire logic        count_up,
  input  wire logic        periodic,
  input  wire logic [1:0]  fmt,
  input  wire logic [3:0]  prescale,
  input  wire logic [31:0] load_value,
  input  wire logic        restart,
  input  wire logic        irq_clear,
  // state
  output logic      [31:0] count,
  output logic             irq,
  output logic             expired
);
  localparam logic [31:0] MASK = (WIDTH == 32) ? 32'hFFFFFFFF : 32'((64'h1 << WIDTH) - 64'h1);

  // width check
  if (WIDTH < 2 || WIDTH > 32) begin : g_chk
    $error("gwt_counter: WIDTH must be 2 to 32");
  end

  // terminal prescale count
  function automatic logic [14:0] pre_limit(input logic [3:0] code);
    if (code == `GWT_PRE_16) pre_limit = `GWT_LIM_16;
    else if (code == `GWT_PRE_256) pre_limit = `GWT_LIM_256;
    else if (code == `GWT_PRE_32K && DIV_32K) pre_limit = `GWT_LIM_32K;
    else pre_limit = 15'h0000;
  endfunction

  // one step of the time-of-day format, wrapping in both directions
  function automatic logic [31:0] hms_step(input logic [31:0] v, input logic up, input logic [31:0] lim);
    logic [31:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (c) begin
        if (up) begin
          if (r[i*8+:8] >= lim[i*8+:8]) r[i*8+:8] = 8'h00;
          else begin
            r[i*8+:8] = r[i*8+:8] + 8'h01;
            c = 1'b0;
          end
        end else begin
          if (r[i*8+:8] == 8'h00) r[i*8+:8] = lim[i*8+:8];
          else begin
            r[i*8+:8] = r[i*8+:8] - 8'h01;
            c = 1'b0;
          end
        end
      end
    end
    hms_step = r;
  endfunction

  gwt_pkg::gwt_cnt_t st_r;
  gwt_pkg::gwt_cnt_t st_nxt;
  logic              hms;
  logic              step;
  logic [31:0]       hlim;
  logic [31:0]       term;

  // format and terminal value
  always_comb begin
    hms = (WIDTH == 32) && fmt[1];
    hlim = {(fmt[0] ? `GWT_HR255 : `GWT_HR23), `GWT_SEC_MAX, `GWT_SEC_MAX, `GWT_HUN_MAX};
    term = count_up ? (hms ? hlim : MASK) : 32'h0;
  end

  // prescaler, counter and interrupt
  always_comb begin
    st_nxt = st_r;
    st_nxt.expired = 1'b0;
    step = 1'b0;
    if (restart) begin
      st_nxt.count = load_value & MASK;
      st_nxt.pre = 15'h0000;
    end else if (enable && tick) begin
      if (st_r.pre >= pre_limit(prescale)) begin
        st_nxt.pre = 15'h0000;
        step = 1'b1;
      end else st_nxt.pre = st_r.pre + 15'h0001;
    end
    if (irq_clear) st_nxt.irq = 1'b0;
    if (step) begin
      if (periodic && st_r.count == term) st_nxt.count = load_value & MASK;
      else if (hms) st_nxt.count = hms_step(st_r.count, count_up, hlim);
      else st_nxt.count = (count_up ? st_r.count + 32'h1 : st_r.count - 32'h1) & MASK;
      if (st_nxt.count == term) begin
        st_nxt.irq = 1'b1;
        st_nxt.expired = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) st_r <= '{count: `GWT_COUNT_RST & MASK, default: '0};
    else st_r <= st_nxt;
  end

  assign count = st_r.count;
  assign irq = st_r.irq;
  assign expired = st_r.expired;
endmodule

// [rtl/gwt_top.sv]
// general-purpose, wake-up and third timers behind an avalon-mm slave
`timescale 1ns/100ps
`include "gwt_consts.svh"
module gwt_top #(
  parameter int unsigned T3_WIDTH = 16
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // avalon-mm slave
  input  wire logic [31:0] avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  // clock source pins
  input  wire logic        xtal_clock_in,
  input  wire logic        osc_clock_in,
  input  wire logic        first_gpio_clock_input,
  input  wire logic        second_gpio_clock_input,
  // system side
  input  wire logic        core_clock_stopped,
  input  wire logic [31:0] event_sources,
  // interrupts and triggers
  output logic             gp_irq,
  output logic             wakeup_irq,
  output logic             third_irq,
  output logic             gp_adc_trigger,
  output logic             adc_trigger
);
  // width check
  if (T3_WIDTH < 2 || T3_WIDTH > 32) begin : g_chk
    $error("gwt_top: T3_WIDTH must be 2 to 32");
  end

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------

  // byte-lane merge of a write
  function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                           input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[i*8+:8] = wd[i*8+:8];
    end
    be_merge = r;
  endfunction

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------

  gwt_pkg::gwt_top_t st_r;
  gwt_pkg::gwt_top_t st_nxt;

  logic [3:0]  edges;
  logic        xtal_tick;
  logic        osc_tick;
  logic        gpio1_tick;
  logic        gpio2_tick;
  logic        core_tick;
  logic        gp_tick;
  logic        wk_tick;
  logic        acc;
  logic        gp_clr_wr;
  logic        wk_clr_wr;
  logic        t3_clr_wr;
  logic        gp_ctrl_wr;
  logic        wk_ctrl_wr;
  logic        t3_ctrl_wr;
  logic [31:0] evt_edge;
  logic        capture;
  logic [31:0] rd;
  logic [31:0] gp_count;
  logic [31:0] wk_count;
  logic [31:0] t3_count;
  logic        gp_irq_w;
  logic        wk_irq_w;
  logic        t3_irq_w;
  logic        gp_exp;
  logic        wk_exp;
  logic        t3_exp;

  //------------------------------------------------------------
  // source ticks
  //------------------------------------------------------------

  // rising edges of the synchronised pins
  assign edges = st_r.sync2 & ~st_r.prev;
  assign xtal_tick = edges[0];
  assign osc_tick = edges[1];
  assign gpio1_tick = edges[2];
  assign gpio2_tick = edges[3];
  // core source halts with the core clock
  assign core_tick = !core_clock_stopped;

  // source selection of the two main timers
  always_comb begin
    case (st_r.gp_ctrl[`GWT_CS_HI:`GWT_CS_LO])
      `GWT_GCS_CORE:  gp_tick = core_tick;
      `GWT_GCS_XTAL:  gp_tick = xtal_tick;
      `GWT_GCS_GPIO1: gp_tick = gpio1_tick;
      `GWT_GCS_GPIO2: gp_tick = gpio2_tick;
      default:        gp_tick = 1'b0;
    endcase
    case (st_r.wk_ctrl[`GWT_WCS_HI:`GWT_CS_LO])
      `GWT_WCS_OSC:  wk_tick = osc_tick;
      `GWT_WCS_CORE: wk_tick = core_tick;
      default:       wk_tick = xtal_tick;
    endcase
  end

  //------------------------------------------------------------
  // bus decode
  //------------------------------------------------------------

  // write strobes, valid in the acknowledge cycle only
  assign acc = (st_r.bus == gwt_pkg::GWT_BUS_ACK) && avs_write;
  assign gp_clr_wr = acc && avs_address == `GWT_GP_CLR;
  assign wk_clr_wr = acc && avs_address == `GWT_WK_CLR;
  assign t3_clr_wr = acc && avs_address == `GWT_T3_CLR;
  assign gp_ctrl_wr = acc && avs_address == `GWT_GP_CTRL;
  assign wk_ctrl_wr = acc && avs_address == `GWT_WK_CTRL;
  assign t3_ctrl_wr = acc && avs_address == `GWT_T3_CTRL;

  // read mux
  always_comb begin
    rd = 32'h0;
    if (avs_address == `GWT_GP_LOAD) rd = st_r.gp_load;
    else if (avs_address == `GWT_GP_COUNT) rd = gp_count;
    else if (avs_address == `GWT_GP_CTRL) rd = st_r.gp_ctrl;
    else if (avs_address == `GWT_GP_CAP) rd = st_r.gp_cap;
    else if (avs_address == `GWT_WK_LOAD) rd = st_r.wk_load;
    else if (avs_address == `GWT_WK_COUNT) rd = wk_count;
    else if (avs_address == `GWT_WK_CTRL) rd = st_r.wk_ctrl;
    else if (avs_address == `GWT_T3_LOAD) rd = st_r.t3_load;
    else if (avs_address == `GWT_T3_COUNT) rd = t3_count;
    else if (avs_address == `GWT_T3_CTRL) rd = st_r.t3_ctrl;
  end

  //------------------------------------------------------------
  // capture event
  //------------------------------------------------------------

  // first assertion of each event line
  assign evt_edge = event_sources & ~st_r.evt_prev;
  // armed capture of the chosen event
  assign capture = st_r.gp_ctrl[`GWT_CAP_EN] && evt_edge[st_r.gp_ctrl[`GWT_EVT_HI:`GWT_EVT_LO]];

  //------------------------------------------------------------
  // next state
  //------------------------------------------------------------

  // bus handshake, registers, synchronisers
  always_comb begin
    st_nxt = st_r;
    st_nxt.sync1 = {second_gpio_clock_input, first_gpio_clock_input, osc_clock_in, xtal_clock_in};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.prev = st_r.sync2;
    st_nxt.evt_prev = event_sources;
    st_nxt.wk_trig = wk_exp;
    st_nxt.gp_trig = gp_exp;
    case (st_r.bus)
      gwt_pkg::GWT_BUS_IDLE: begin
        if (avs_read || avs_write) begin
          st_nxt.bus = gwt_pkg::GWT_BUS_ACK;
          st_nxt.wreq = 1'b0;
          st_nxt.rdata = avs_read ? rd : 32'h0;
        end
      end
      gwt_pkg::GWT_BUS_ACK: begin
        st_nxt.bus = gwt_pkg::GWT_BUS_IDLE;
        st_nxt.wreq = 1'b1;
        if (avs_write) begin
          if (avs_address == `GWT_GP_LOAD) begin
            st_nxt.gp_load = be_merge(st_r.gp_load, avs_writedata, avs_byteenable);
          end else if (avs_address == `GWT_GP_CTRL) begin
            st_nxt.gp_ctrl = be_merge(st_r.gp_ctrl, avs_writedata, avs_byteenable) & `GWT_GP_MASK;
          end else if (avs_address == `GWT_GP_CAP) begin
            st_nxt.gp_cap = be_merge(st_r.gp_cap, avs_writedata, avs_byteenable);
          end else if (avs_address == `GWT_WK_LOAD) begin
            st_nxt.wk_load = be_merge(st_r.wk_load, avs_writedata, avs_byteenable);
          end else if (avs_address == `GWT_WK_CTRL) begin
            st_nxt.wk_ctrl = be_merge(st_r.wk_ctrl, avs_writedata, avs_byteenable) & `GWT_WK_MASK;
          end else if (avs_address == `GWT_T3_LOAD) begin
            st_nxt.t3_load = be_merge(st_r.t3_load, avs_writedata, avs_byteenable);
          end else if (avs_address == `GWT_T3_CTRL) begin
            st_nxt.t3_ctrl = be_merge(st_r.t3_ctrl, avs_writedata, avs_byteenable) & `GWT_T3_MASK;
          end
        end
      end
      default: begin
        st_nxt.bus = gwt_pkg::GWT_BUS_IDLE;
        st_nxt.wreq = 1'b1;
      end
    endcase
    // capture wins over a software write
    if (capture) st_nxt.gp_cap = gp_count;
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) st_r <= '{bus: gwt_pkg::GWT_BUS_IDLE, wreq: 1'b1, default: '0};
    else st_r <= st_nxt;
  end

  //------------------------------------------------------------
  // counter channels
  //------------------------------------------------------------

  // general-purpose timer
  // enable and mode bits drive the channel
  gwt_counter #(
    .WIDTH   (32),
    .DIV_32K (1'b1)
  ) u_gp (
    .clk        (clk),
    .rst        (rst),
    .tick       (gp_tick),
    .enable     (st_r.gp_ctrl[`GWT_EN]),
    .count_up   (st_r.gp_ctrl[`GWT_UP]),
    .periodic   (st_r.gp_ctrl[`GWT_PER]),
    .fmt        (st_r.gp_ctrl[`GWT_FMT_HI:`GWT_FMT_LO]),
    .prescale   (st_r.gp_ctrl[`GWT_PRE_HI:`GWT_PRE_LO]),
    .load_value (st_r.gp_load),
    .restart    (gp_ctrl_wr),
    .irq_clear  (gp_clr_wr),
    .count      (gp_count),
    .irq        (gp_irq_w),
    .expired    (gp_exp)
  );

  // wake-up timer
  gwt_counter #(
    .WIDTH   (32),
    .DIV_32K (1'b1)
  ) u_wk (
    .clk        (clk),
    .rst        (rst),
    .tick       (wk_tick),
    .enable     (st_r.wk_ctrl[`GWT_EN]),
    .count_up   (st_r.wk_ctrl[`GWT_UP]),
    .periodic   (st_r.wk_ctrl[`GWT_PER]),
    .fmt        (st_r.wk_ctrl[`GWT_FMT_HI:`GWT_FMT_LO]),
    .prescale   (st_r.wk_ctrl[`GWT_PRE_HI:`GWT_PRE_LO]),
    .load_value (st_r.wk_load),
    .restart    (wk_ctrl_wr),
    .irq_clear  (wk_clr_wr),
    .count      (wk_count),
    .irq        (wk_irq_w),
    .expired    (wk_exp)
  );

  // third timer, normal mode
  // oscillator source, divide 1, 16 or 256
  gwt_counter #(
    .WIDTH   (T3_WIDTH),
    .DIV_32K (1'b0)
  ) u_t3 (
    .clk        (clk),
    .rst        (rst),
    .tick       (osc_tick),
    .enable     (st_r.t3_ctrl[`GWT_EN]),
    .count_up   (st_r.t3_ctrl[`GWT_UP]),
    .periodic   (st_r.t3_ctrl[`GWT_PER]),
    .fmt        (2'b00),
    .prescale   ({st_r.t3_ctrl[`GWT_PRE_HI:`GWT_T3P_LO], 2'b00}),
    .load_value (st_r.t3_load),
    .restart    (t3_ctrl_wr),
    .irq_clear  (t3_clr_wr),
    .count      (t3_count),
    .irq        (t3_irq_w),
    .expired    (t3_exp)
  );

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------

  // all from flip-flops
  assign avs_readdata = st_r.rdata;
  assign avs_waitrequest = st_r.wreq;
  assign gp_irq = gp_irq_w;
  assign wakeup_irq = wk_irq_w;
  assign third_irq = t3_irq_w;
  assign gp_adc_trigger = st_r.gp_trig;
  assign adc_trigger = st_r.wk_trig;
endmodule

// [tb/gwt_top_props.sv]
// assertions on the ports of the timer block top
`timescale 1ns/100ps
`include "gwt_consts.svh"
module gwt_top_props #(
  parameter int unsigned T3_WIDTH = 16
) (
  // clock, reset and bus
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [31:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  // interrupts and triggers
  input wire logic        gp_irq,
  input wire logic        wakeup_irq,
  input wire logic        gp_adc_trigger,
  input wire logic        adc_trigger
);
  //----------------------------------------
  // sequences
  //----------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // request seen by an idle slave
  sequence s_taken;
    (avs_read || avs_write) && avs_waitrequest && $past(avs_waitrequest);
  endsequence
  // one-cycle acknowledge
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence
  //----------------------------------------
  // properties
  //----------------------------------------
  chk_bus_ack_once: assert property (s_taken |=> s_ack)
    else $error("bus ack missing or longer than one cycle");
  chk_reset_quiet: assert property ($fell(rst) |-> avs_waitrequest && !gp_irq && !wakeup_irq && !adc_trigger)
    else $error("outputs not idle after reset");
  chk_clear_reads_zero: assert property (avs_read && avs_waitrequest && $past(avs_waitrequest)
    && avs_address == `GWT_GP_CLR |=> avs_readdata == 32'h0)
    else $error("clear location read not zero");
  chk_gp_trig_follows: assert property ($rose(gp_irq) |=> gp_adc_trigger)
    else $error("gp trigger not one cycle after interrupt");
  chk_wk_trig_follows: assert property ($rose(wakeup_irq) |=> adc_trigger)
    else $error("wake-up trigger not one cycle after interrupt");
  chk_wk_trig_cause: assert property (adc_trigger |-> $past(wakeup_irq))
    else $error("wake-up trigger without terminal count");
  chk_gp_trig_pulse: assert property (gp_adc_trigger |=> !gp_adc_trigger)
    else $error("gp trigger longer than one cycle");
  chk_wk_irq_holds: assert property (wakeup_irq && !(avs_write && !avs_waitrequest
    && avs_address == `GWT_WK_CLR) |=> wakeup_irq)
    else $error("wake-up interrupt dropped without clear");
  chk_gp_irq_clears: assert property (avs_write && !avs_waitrequest && avs_address == `GWT_GP_CLR
    |=> (!gp_irq) or (##1 gp_adc_trigger))
    else $error("gp interrupt not cleared by write");
  chk_wk_irq_clears: assert property (avs_write && !avs_waitrequest && avs_address == `GWT_WK_CLR
    |=> (!wakeup_irq) or (##1 adc_trigger))
    else $error("wake-up interrupt not cleared by write");
endmodule

bind gwt_top gwt_top_props #(.T3_WIDTH(T3_WIDTH)) u_props (.clk(clk), .rst(rst), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .gp_irq(gp_irq), .wakeup_irq(wakeup_irq), .gp_adc_trigger(gp_adc_trigger), .adc_trigger(adc_trigger));

// [tb/tb.sv]
// self-checking testbench of the timer block
`timescale 1ns/100ps
`include "gwt_consts.svh"
module tb;
  //----------------------------------------
  // signals
  //----------------------------------------
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] avs_address = 32'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        core_clock_stopped = 1'b0;
  logic [31:0] event_sources = 32'h0;
  logic        gp_irq, wakeup_irq, third_irq, gp_adc_trigger, adc_trigger;
  logic [31:0] cyc = 32'h0;
  int          mismatches = 0;
  int          n_tests = 0;
  logic [31:0] rd;
  logic [31:0] v;
  int          k;
  // reset image and period table
  logic [31:0] r_a[8] = '{`GWT_GP_COUNT, `GWT_WK_COUNT, `GWT_GP_CTRL, `GWT_WK_CTRL, `GWT_GP_CAP, `GWT_WK_LOAD,
                          `GWT_GP_CLR, 32'hFFFF0000};
  logic [31:0] r_v[8] = '{`GWT_COUNT_RST, `GWT_COUNT_RST, 0, 0, 0, 0, 0, 0};
  logic        t_wk[18] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1};
  logic [31:0] t_ld[18] = '{2, 2, 2, 2, 1, 1, 1, 1, 32'hFFFFFFFD, 32'hFFFFFFFD, 32'h173B3B61, 32'hFF3B3B61,
                            2, 2, 2, 2, 1, 32'hFFFFFFFE};
  logic [31:0] t_c[18] = '{32'h0C0, 32'h2C0, 32'h4C0, 32'h6C0, 32'h0C0, 32'h0C4, 32'h0C8, 32'h0C2, 32'h1C0,
                           32'h1D0, 32'h1E0, 32'h1F0, 32'h0C0, 32'h2C0, 32'h4C0, 32'h6C0, 32'h6E8, 32'h7C0};

  //----------------------------------------
  // clock, pins, timeout, design
  //----------------------------------------
  always #50 clk = ~clk;
  // free-running count feeds the slow source pins
  always @(posedge clk) begin
    cyc <= cyc + 32'h1;
    if (cyc == 32'h0000EA60) begin
      mismatches++;
      conclude();
    end
  end
  gwt_top uut (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .xtal_clock_in(cyc[2]), .osc_clock_in(cyc[4]),
    .first_gpio_clock_input(cyc[1]), .second_gpio_clock_input(cyc[3]),
    .core_clock_stopped(core_clock_stopped), .event_sources(event_sources), .gp_irq(gp_irq),
    .wakeup_irq(wakeup_irq), .third_irq(third_irq), .gp_adc_trigger(gp_adc_trigger),
    .adc_trigger(adc_trigger));

  //----------------------------------------
  // tasks and model
  //----------------------------------------
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  // cycles between terminal counts: source period, divider, steps
  function automatic int model(input bit wk, input logic [31:0] ld, input logic [31:0] c);
    int per;
    int div;
    logic [31:0] term;
    if (wk) per = c[10] ? (c[9] ? 1 : 32) : 8;
    else per = (c[11:9] == 3'h0) ? 1 : (c[11:9] == 3'h1) ? 8 : (c[11:9] == 3'h2) ? 4 : 16;
    case (c[3:0])
      4'h4: div = 16;
      4'h8: div = 256;
      default: div = 1;
    endcase
    term = c[5] ? {c[4] ? `GWT_HR255 : `GWT_HR23, 24'h3B3B63} : 32'hFFFFFFFF;
    return per * div * (c[8] ? int'(term - ld) + 1 : int'(ld) + 1);
  endfunction
  // program a channel and measure trigger spacing
  task automatic period(input bit wk, input logic [31:0] ld, input logic [31:0] c);
    int n;
    wr(wk ? `GWT_WK_LOAD : `GWT_GP_LOAD, ld);
    wr(wk ? `GWT_WK_CTRL : `GWT_GP_CTRL, c);
    repeat (2) begin
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while ((wk ? adc_trigger : gp_adc_trigger) !== 1'b1 && n < 1000);
    end
    compare("period", model(wk, ld, c), n);
  endtask

  //----------------------------------------
  // main sequence
  //----------------------------------------
  initial begin
    void'($urandom(32'had74));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 8; k++) begin
      bus(1'b0, r_a[k], 32'h0, rd);
      compare("reset image", r_v[k], rd);
    end
    wr(`GWT_WK_COUNT, $urandom);
    bus(1'b0, `GWT_WK_COUNT, 32'h0, rd);
    compare("wake count write", `GWT_COUNT_RST, rd);
    for (k = 0; k < 18; k++) period(t_wk[k], t_ld[k], t_c[k]);
    v = $urandom_range(40, 2);
    period(1'b0, v, 32'h0C0);
    wr(`GWT_GP_CTRL, 32'h0);
    repeat (5) @(posedge clk);
    bus(1'b0, `GWT_GP_COUNT, 32'h0, rd);
    compare("gp halted", v, rd);
    compare("gp irq pending", 32'h1, {31'h0, gp_irq});
    wr(`GWT_GP_CLR, $urandom);
    @(negedge clk);
    compare("gp irq cleared", 32'h0, {31'h0, gp_irq});
    // wake-up free-run down from 3, then clear
    wr(`GWT_WK_LOAD, 32'h3);
    wr(`GWT_WK_CTRL, 32'h680);
    // let a trigger left over from the old setting pass
    repeat (2) @(posedge clk);
    k = 0;
    while (adc_trigger !== 1'b1 && k < 50) begin
      @(posedge clk);
      k++;
    end
    wr(`GWT_WK_CLR, $urandom);
    @(negedge clk);
    compare("wake irq cleared", 32'h0, {31'h0, wakeup_irq});
    bus(1'b0, `GWT_WK_COUNT, 32'h0, rd);
    compare("wake wrap", 32'h00FFFFFF, {8'h0, rd[31:8]});
    // third timer in normal mode, free-run down from 2, then clear
    wr(`GWT_T3_LOAD, 32'h2);
    wr(`GWT_T3_CTRL, 32'h080);
    repeat (120) @(posedge clk);
    compare("third irq pending", 32'h1, {31'h0, third_irq});
    bus(1'b0, `GWT_T3_COUNT, 32'h0, rd);
    compare("third wrap", 32'h000000FF, {8'h0, rd[31:8]});
    wr(`GWT_T3_CLR, $urandom);
    @(negedge clk);
    compare("third irq cleared", 32'h0, {31'h0, third_irq});
    // capture on selected event only, and only while armed
    v = $urandom;
    k = $urandom_range(31, 0);
    wr(`GWT_GP_LOAD, v);
    wr(`GWT_GP_CTRL, 32'h20000 | (32'(k) << 12));
    event_sources <= 32'h1 << (k ^ 1);
    @(posedge clk);
    event_sources <= 32'h0;
    bus(1'b0, `GWT_GP_CAP, 32'h0, rd);
    compare("capture other event", 32'h0, rd);
    event_sources <= 32'h1 << k;
    @(posedge clk);
    event_sources <= 32'h0;
    bus(1'b0, `GWT_GP_CAP, 32'h0, rd);
    compare("capture value", v, rd);
    wr(`GWT_GP_LOAD, ~v);
    wr(`GWT_GP_CTRL, 32'(k) << 12);
    event_sources <= 32'h1 << k;
    @(posedge clk);
    event_sources <= 32'h0;
    bus(1'b0, `GWT_GP_CAP, 32'h0, rd);
    compare("capture disarmed", v, rd);
    // core clock stopped: oscillator keeps wake-up running
    core_clock_stopped <= 1'b1;
    period(1'b1, 32'h2, 32'h4C0);
    wr(`GWT_GP_LOAD, 32'h3E8);
    wr(`GWT_GP_CTRL, 32'h080);
    repeat (8) @(posedge clk);
    bus(1'b0, `GWT_GP_COUNT, 32'h0, rd);
    compare("gp core stopped", 32'h3E8, rd);
    core_clock_stopped <= 1'b0;
    conclude();
  end
endmodule
